//--- inc/disc_write_pkg.sv
package disc_write_pkg;
  localparam int WORD_W = 16;
  localparam int BUF_DEPTH = 16;
  localparam int ADDR_W = 4;
  localparam int WORDS_PER_SUB = 16;
  localparam int CODE_BITS = 16;
  localparam logic [7:0] LAST_WORD_AT = 8'hf0;
  localparam logic [7:0] LAST_DATA_BIT = 8'hff;
  localparam logic [3:0] LAST_BIT_IN_WORD = 4'hf;
  localparam int CLK_PERIOD_NS = 10;
  localparam int END_PULSE_NS = 200;
  // a longest time: rounds down, never below one cycle
  localparam int END_PULSE_CYC = (END_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (END_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [7:0] PERIOD_RESET = 8'h01;
  typedef enum logic [2:0] {
    IDLE = 3'h0,
    FILL = 3'h1,
    GO = 3'h3,
    DATA = 3'h2,
    CODE = 3'h6,
    PARITY = 3'h7,
    ENDP = 3'h5
  } seq_type;
endpackage : disc_write_pkg

//--- hw/disc_write_buffer_serializer.sv
`timescale 1ns/1ps
module disc_write_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [AW-1:0] rd_addr_o,
  output logic [AW:0] count_o
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] rd_addr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o && ce_i;
  wire pop = out_valid_o && out_ready_i && ce_i;
  // full at exactly DEPTH words; both pointers wrap modulo DEPTH
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_addr];
  assign rd_addr_o = rd_addr;
  assign count_o = count;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_addr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_addr <= '0;
      rd_addr <= '0;
      count <= '0;
    end else if (clear_i && ce_i) begin
      wr_addr <= '0;
      rd_addr <= '0;
      count <= '0;
    end else begin
      if (push) wr_addr <= wr_addr + 1'b1;
      if (pop) rd_addr <= rd_addr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : disc_write_fifo

module disc_write_buffer_serializer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic write_operation_flag_i,
  input wire logic channel_out_transfer_i,
  input wire logic [15:0] host_data_i,
  input wire logic end_of_operation_i,
  input wire logic write_clock_i,
  input wire logic sector_match_i,
  output logic host_ready_o,
  output logic write_data_n_o,
  output logic write_gate_n_o,
  output logic write_sector_go_n_o,
  output logic shifter_parallel_load_n_o,
  output logic last_word_flag_o,
  output logic code_word_phase_o,
  output logic parity_phase_o,
  output logic subsector_end_pulse_n_o,
  output logic buffer_empty_flag_o
);
  localparam int W = disc_write_pkg::WORD_W;
  localparam int AW = disc_write_pkg::ADDR_W;

  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  wire ce = enable_i;
  disc_write_pkg::seq_type state;
  disc_write_pkg::seq_type next_state;

  // pins from the drive: three flops, a change counts once stages 2 and 3 agree
  logic [2:0] wclk_s;
  logic [2:0] smatch_s;
  logic wclk_q;
  logic smatch_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wclk_s <= '0;
      smatch_s <= '0;
      wclk_q <= 1'b0;
      smatch_q <= 1'b0;
    end else if (ce) begin
      wclk_s <= {wclk_s[1:0], write_clock_i};
      smatch_s <= {smatch_s[1:0], sector_match_i};
      if (wclk_s[1] == wclk_s[2]) wclk_q <= wclk_s[2];
      if (smatch_s[1] == smatch_s[2]) smatch_q <= smatch_s[2];
    end
  end
  wire wclk_rise = ce && (wclk_s[1] == wclk_s[2]) && wclk_s[2] && !wclk_q;

  // host side: input register and buffer load
  logic wop_d;
  logic pending;
  logic [W-1:0] in_reg;
  wire start = ce && write_operation_flag_i && !wop_d;
  wire strobe = ce && channel_out_transfer_i && write_operation_flag_i && !pending;
  wire fifo_ready;
  wire push = pending && fifo_ready && ce;
  wire next_pending = start ? 1'b0 : (strobe ? 1'b1 : (push ? 1'b0 : pending));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wop_d <= 1'b0;
      pending <= 1'b0;
      in_reg <= '0;
      host_ready_o <= 1'b0;
    end else if (ce) begin
      wop_d <= write_operation_flag_i;
      pending <= next_pending;
      host_ready_o <= !next_pending && write_operation_flag_i;
      if (strobe && !start) in_reg <= host_data_i;
    end
  end

  wire fifo_valid;
  wire [W-1:0] fifo_data;
  wire [AW-1:0] rd_addr;
  wire [AW:0] count;
  logic pop;
  wire full = !fifo_ready;

  disc_write_fifo #(
    .W(W),
    .DEPTH(disc_write_pkg::BUF_DEPTH),
    .AW(AW)
  ) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce),
    .clear_i(start),
    .in_valid_i(pending),
    .in_ready_o(fifo_ready),
    .in_data_i(in_reg),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data),
    .rd_addr_o(rd_addr),
    .count_o(count)
  );

  // disc side
  logic write_latch;
  logic [W-1:0] shifter;
  logic [7:0] bit_count;
  logic [3:0] code_count;
  logic [15:0] crc;
  logic par;
  logic par_sent;
  logic [7:0] period_cnt;
  logic [7:0] period;
  logic [8:0] hold;
  logic [7:0] end_cnt;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? disc_write_pkg::CRC_POLY : 16'h0000);
  endfunction : crc_step

  // drive write clock edges are the shift clock once the latch is set
  wire shift_tick = wclk_rise && write_latch;
  wire in_data = (state == disc_write_pkg::DATA);
  wire cur_bit = in_data ? ~shifter[0] :
                 (state == disc_write_pkg::CODE) ? crc[15] : ~par;
  wire word_end = in_data && (bit_count[3:0] == disc_write_pkg::LAST_BIT_IN_WORD) &&
                  (bit_count != disc_write_pkg::LAST_DATA_BIT);
  wire load_release = ce && !shifter_parallel_load_n_o && in_data && (hold == 9'h001);
  wire go_release = ce && (state == disc_write_pkg::GO) && smatch_q;
  wire end_done = (state == disc_write_pkg::ENDP) && (end_cnt == 8'h01);
  // the parity bit takes one shift clock, the end pulse starts on the one after it
  wire par_tick = shift_tick && (state == disc_write_pkg::PARITY) && !par_sent;
  wire end_tick = shift_tick && (state == disc_write_pkg::PARITY) && par_sent;
  assign pop = go_release || load_release;

  always_comb begin
    next_state = state;
    unique case (state)
      disc_write_pkg::IDLE: if (start) next_state = disc_write_pkg::FILL;
      disc_write_pkg::FILL: if (full) next_state = disc_write_pkg::GO;
      disc_write_pkg::GO: if (smatch_q) next_state = disc_write_pkg::DATA;
      disc_write_pkg::DATA: begin
        if (shift_tick && bit_count == disc_write_pkg::LAST_DATA_BIT) begin
          next_state = disc_write_pkg::CODE;
        end
      end
      disc_write_pkg::CODE: if (shift_tick && code_count == 4'hf) next_state = disc_write_pkg::PARITY;
      disc_write_pkg::PARITY: if (end_tick) next_state = disc_write_pkg::ENDP;
      disc_write_pkg::ENDP: begin
        if (end_done) begin
          next_state = (end_of_operation_i && !fifo_valid) ?
                       disc_write_pkg::IDLE : disc_write_pkg::FILL;
        end
      end
      default: next_state = disc_write_pkg::IDLE;
    endcase
    if (!write_operation_flag_i) next_state = disc_write_pkg::IDLE;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= disc_write_pkg::IDLE;
      write_sector_go_n_o <= 1'b1;
      shifter_parallel_load_n_o <= 1'b1;
      write_latch <= 1'b0;
      shifter <= '0;
      bit_count <= '0;
      code_count <= '0;
      crc <= disc_write_pkg::CRC_INIT;
      par <= 1'b0;
      par_sent <= 1'b0;
      last_word_flag_o <= 1'b0;
      code_word_phase_o <= 1'b0;
      parity_phase_o <= 1'b0;
      subsector_end_pulse_n_o <= 1'b1;
      end_cnt <= '0;
      hold <= '0;
    end else if (ce) begin
      state <= next_state;
      // phase flags change together with the write data, so they mark the bit on the line
      if (shift_tick) begin
        code_word_phase_o <= (state == disc_write_pkg::CODE);
        parity_phase_o <= par_tick;
      end
      if (par_tick) par_sent <= 1'b1;
      if (state == disc_write_pkg::FILL && full) begin
        write_sector_go_n_o <= 1'b0;
        shifter_parallel_load_n_o <= 1'b0;
        shifter <= ~fifo_data;
      end
      if (go_release) begin
        write_sector_go_n_o <= 1'b1;
        shifter_parallel_load_n_o <= 1'b1;
        write_latch <= 1'b1;
        bit_count <= '0;
        code_count <= '0;
        crc <= disc_write_pkg::CRC_INIT;
        par <= 1'b0;
        par_sent <= 1'b0;
        last_word_flag_o <= 1'b0;
      end
      if (shift_tick) begin
        par <= par ^ cur_bit;
        if (in_data) begin
          crc <= crc_step(crc, cur_bit);
          bit_count <= bit_count + 8'h01;
          if (bit_count == disc_write_pkg::LAST_WORD_AT - 8'h01) last_word_flag_o <= 1'b1;
          if (word_end) begin
            // this word's location is freed to the host only when the load pulse ends, while this word shifts
            shifter <= ~fifo_data;
            shifter_parallel_load_n_o <= 1'b0;
            hold <= 9'(period) + 9'(period >> 1);
          end else begin
            shifter <= shifter >> 1;
          end
        end else if (state == disc_write_pkg::CODE) begin
          crc <= crc << 1;
          code_count <= code_count + 4'h1;
        end
      end else if (!shifter_parallel_load_n_o && in_data && hold != 9'h000) begin
        hold <= hold - 9'h001;
      end
      if (load_release) shifter_parallel_load_n_o <= 1'b1;
      if (end_tick) begin
        subsector_end_pulse_n_o <= 1'b0;
        end_cnt <= 8'(disc_write_pkg::END_PULSE_CYC);
        write_latch <= 1'b0;
        last_word_flag_o <= 1'b0;
      end else if (state == disc_write_pkg::ENDP) begin
        end_cnt <= end_cnt - 8'h01;
        if (end_done) subsector_end_pulse_n_o <= 1'b1;
      end
      if (next_state == disc_write_pkg::IDLE) begin
        write_sector_go_n_o <= 1'b1;
        shifter_parallel_load_n_o <= 1'b1;
        write_latch <= 1'b0;
        subsector_end_pulse_n_o <= 1'b1;
        code_word_phase_o <= 1'b0;
        parity_phase_o <= 1'b0;
      end
    end
  end

  // bit time measured between write clock edges, used for the load hold
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= disc_write_pkg::PERIOD_RESET;
      period <= disc_write_pkg::PERIOD_RESET;
    end else if (ce) begin
      if (wclk_rise) begin
        period <= period_cnt;
        period_cnt <= disc_write_pkg::PERIOD_RESET;
      end else if (period_cnt != 8'hff) begin
        period_cnt <= period_cnt + 8'h01;
      end
    end
  end

  // write data and write gate flops, clocked by drive write clock edges
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      write_data_n_o <= 1'b1;
      write_gate_n_o <= 1'b1;
      buffer_empty_flag_o <= 1'b1;
    end else if (ce) begin
      buffer_empty_flag_o <= (count == '0);
      if (wclk_rise) write_gate_n_o <= !write_latch;
      if (shift_tick) write_data_n_o <= ~cur_bit;
    end
  end

  a_strobe_capture: assert property (@(posedge clk_i) disable iff (!rst_n)
    strobe && !start |=> pending && in_reg == $past(host_data_i))
    else $error("host word not captured");
  a_start_clears: assert property (@(posedge clk_i) disable iff (!rst_n)
    start |=> count == '0 && rd_addr == '0)
    else $error("write start did not clear buffer");
  a_full_go: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce && state == disc_write_pkg::FILL && full |=>
    !write_sector_go_n_o && !shifter_parallel_load_n_o && shifter == ~$past(fifo_data))
    else $error("full buffer did not start go");
  a_go_advance: assert property (@(posedge clk_i) disable iff (!rst_n)
    go_release |=> write_sector_go_n_o && rd_addr == $past(rd_addr) + 1'b1)
    else $error("go release did not advance read address");
  a_count_track: assert property (@(posedge clk_i) disable iff (!rst_n)
    push && !pop && !start |=> count == $past(count) + 1'b1)
    else $error("contents counter did not count up");
  a_bit_out: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_tick && in_data |=> write_data_n_o == $past(shifter[0]))
    else $error("serial bit wrong");
  a_last_word: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_tick && in_data && bit_count == 8'hef |=> last_word_flag_o)
    else $error("last word flag late");
  a_code_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_tick && state == disc_write_pkg::CODE && code_count == 4'h0 |=>
    code_word_phase_o && !parity_phase_o)
    else $error("code phase not entered");
  a_end_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(subsector_end_pulse_n_o) |-> !subsector_end_pulse_n_o[*8])
    else $error("end pulse too short");
endmodule : disc_write_buffer_serializer

//--- testbench/disc_drive_model.sv
`timescale 1ns/1ps
module disc_drive_model (
  input wire logic run_i,
  input wire logic write_data_n_i,
  input wire logic write_gate_n_i,
  input wire logic last_word_i,
  input wire logic code_i,
  input wire logic parity_i,
  input wire logic end_n_i,
  output logic write_clock_o
);
  logic bits [0:299];
  int nbits = 0;
  int ncode = 0;
  int npar = 0;
  int nlast = 0;
  logic ended = 1'b0;

  initial write_clock_o = 1'b0;

  // stands still outside the frame; 7 ns idle steps keep its phase off the bench clock
  always begin
    if (run_i) begin
      write_clock_o = 1'b1;
      #80;
      write_clock_o = 1'b0;
      #80;
    end else begin
      #7;
    end
  end

  always @(negedge end_n_i) ended = 1'b1;

  // the drive reads the line half a bit after its own edge, while the gate is open
  always @(negedge write_clock_o) begin
    if (write_gate_n_i === 1'b0 && !ended && nbits < 300) begin
      bits[nbits] = ~write_data_n_i;
      nbits++;
      if (code_i === 1'b1) ncode++;
      if (parity_i === 1'b1) npar++;
      if (last_word_i === 1'b1) nlast++;
    end
  end
endmodule : disc_drive_model

//--- testbench/disc_write_buffer_serializer_tb_top.sv
`timescale 1ns/1ps
module disc_write_buffer_serializer_tb_top;
  typedef struct packed {logic [15:0] word; logic [15:0] serial;} row_type;
  // serial holds the expected stream, bit i being the i-th bit on the wire
  row_type rows [16] = '{'{16'h0001, 16'h0001}, '{16'h8000, 16'h8000},
    '{16'hffff, 16'hffff}, '{16'h0000, 16'h0000}, '{16'ha5a5, 16'ha5a5},
    '{16'h5a5a, 16'h5a5a}, '{16'h1234, 16'h1234}, '{16'hfedc, 16'hfedc},
    '{16'h00ff, 16'h00ff}, '{16'hff00, 16'hff00}, '{16'h0f0f, 16'h0f0f},
    '{16'hf0f0, 16'hf0f0}, '{16'h7fff, 16'h7fff}, '{16'hfffe, 16'hfffe},
    '{16'h3c3c, 16'h3c3c}, '{16'hc001, 16'hc001}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_flag = 1'b0;
  logic strobe = 1'b0;
  logic [15:0] data = 16'h0000;
  logic match = 1'b0;
  logic run = 1'b0;
  logic wclk, ready, wdn, gate_n, go_n, load_n, last, code, par, end_n, empty;
  int failures = 0;
  int checked = 0;
  int lw = 0;
  int lastlw = 0;
  int i;
  int b;
  int n;
  int ones;
  logic [15:0] got;

  initial begin
    forever #5 clk = ~clk;
  end

  disc_write_buffer_serializer disc_write_buffer_serializer_i (.clk_i(clk),
    .reset_n_i(reset_n), .enable_i(1'b1), .write_operation_flag_i(wr_flag),
    .channel_out_transfer_i(strobe), .host_data_i(data), .end_of_operation_i(1'b1),
    .write_clock_i(wclk), .sector_match_i(match), .host_ready_o(ready),
    .write_data_n_o(wdn), .write_gate_n_o(gate_n), .write_sector_go_n_o(go_n),
    .shifter_parallel_load_n_o(load_n), .last_word_flag_o(last),
    .code_word_phase_o(code), .parity_phase_o(par), .subsector_end_pulse_n_o(end_n),
    .buffer_empty_flag_o(empty));

  disc_drive_model disc_drive_model_i (.run_i(run), .write_data_n_i(wdn),
    .write_gate_n_i(gate_n), .last_word_i(last), .code_i(code), .parity_i(par),
    .end_n_i(end_n), .write_clock_o(wclk));

  // width of each parallel-load pulse while writing
  always @(posedge clk) begin
    if (load_n === 1'b0 && gate_n === 1'b0) lw++;
    else if (lw > 0) begin
      lastlw = lw;
      lw = 0;
    end
  end

  task automatic chk_vec(input logic [15:0] g, input logic [15:0] e, input string msg);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, g, e);
    end
  endtask : chk_vec

  task automatic chk_cnt(input int g, input int e, input string msg);
    checked++;
    if (g != e) begin
      failures++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, g, e);
    end
  endtask : chk_cnt

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  function automatic logic seen(input int which);
    case (which)
      0: return ready === 1'b1;
      1: return go_n === 1'b0;
      2: return go_n === 1'b1;
      default: return end_n === 1'b0;
    endcase
  endfunction : seen

  // samples one step after the edge so that the edge's own updates have landed
  task automatic wait_until(input int which, input int bound);
    int k;
    for (k = 0; k < bound; k++) begin
      @(posedge clk);
      #1;
      if (seen(which)) return;
    end
    failures++;
    $display("wrong value at %0t: wait %0d ran out", $time, which);
    tally_and_finish();
  endtask : wait_until

  task automatic host_word(input logic [15:0] d);
    wait_until(0, 100);
    @(posedge clk);
    strobe <= 1'b1;
    data <= d;
    @(posedge clk);
    strobe <= 1'b0;
  endtask : host_word

  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk_vec({go_n, load_n, end_n, wdn, gate_n, last, code, par, ready, empty},
      16'h03e1, "reset values");
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr_flag <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 16; i++) host_word(rows[i].word);
    wait_until(1, 200);
    chk_vec(load_n, 1'b0, "load with go");
    chk_vec(empty, 1'b0, "empty when full");
    run <= 1'b1;
    repeat (100) @(posedge clk);
    chk_cnt(disc_drive_model_i.nbits, 0, "bits before match");
    match <= 1'b1;
    wait_until(2, 200);
    wait_until(3, 10000);
    n = 0;
    while (end_n === 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_cnt(n, disc_write_pkg::END_PULSE_CYC, "end pulse width");
    run <= 1'b0;
    match <= 1'b0;
    chk_cnt(disc_drive_model_i.nbits, 273, "bits in subsector");
    for (i = 0; i < 16; i++) begin
      for (b = 0; b < 16; b++) got[b] = disc_drive_model_i.bits[i * 16 + b];
      chk_vec(got, rows[i].serial, "serial word");
    end
    ones = 0;
    for (b = 0; b < 273; b++) ones += (disc_drive_model_i.bits[b] === 1'b1);
    chk_cnt(ones % 2, 1, "odd parity");
    chk_cnt(disc_drive_model_i.ncode, 16, "code bits");
    chk_cnt(disc_drive_model_i.npar, 1, "parity bits");
    chk_vec(disc_drive_model_i.nlast == 33 || disc_drive_model_i.nlast == 34, 1'b1,
      "last word span");
    chk_vec(lastlw >= 21 && lastlw <= 27, 1'b1, "load width");
    repeat (3) @(posedge clk);
    #1;
    chk_vec({empty, go_n, code, par}, 4'hc, "after end");
    tally_and_finish();
  end
endmodule : disc_write_buffer_serializer_tb_top
